/* rtl/two_wire_slave_engine.sv */
/*
  Slave engine of a byte-oriented two-wire interface with AXI4-Lite
  registers. Assumes an external master on open-drain lines, pulled up
  outside; lines arrive asynchronously and are synchronised here.
*/
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module two_wire_slave_engine (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire two_wire_pkg::addr_t awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire two_wire_pkg::word_t wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire two_wire_pkg::addr_t araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output two_wire_pkg::word_t    rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe
);
  import two_wire_pkg::*;

  typedef struct packed {
    phase_t     phase;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] data;
    logic [7:0] oar;
    logic       ack_en;
    logic       begin_req;
    logic       halt_req;
    logic       wcol;
    logic       en;
    logic       irq_en;
    logic       job_done;
    logic [7:0] status;
    logic       addressed;
    logic       gc;
    logic       rd;
    logic       ack_plan;
    logic       last;
    logic       mack;
    logic       busy;
    logic       pend;
    logic       arb;
    logic [8:0] timer;
    logic       scl_oe;
    logic       sda_oe;
    logic       aw_got;
    addr_t      aw_addr;
    logic       w_got;
    logic [7:0] wbyte;
    logic       wstrb0;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    word_t      rdata;
    logic [1:0] rresp;
  } state_t;

  state_t s;
  state_t n;

  logic [1:0] lines_s;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;

  // ==========================================================
  // line sampling
  bit_sync #(.W(2)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({scl_i, sda_i}),
    .q       (lines_s)
  );
  assign scl_s = lines_s[1];
  assign sda_s = lines_s[0];

  line_events u_events (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .scl       (scl_s),
    .sda       (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  function automatic logic is_exit(input logic [7:0] c);
    is_exit = (c == ST_SR_DNACK) || (c == ST_GC_DNACK) ||
              (c == ST_STOP) || (c == ST_ST_DNACK) || (c == ST_ST_LAST);
  endfunction : is_exit

  // ==========================================================
  // next state
  always_comb begin
    logic sw_clear;
    logic hw_set;
    logic own;
    logic gcm;
    sw_clear = 1'b0;
    hw_set   = 1'b0;
    own      = 1'b0;
    gcm      = 1'b0;
    n        = s;

    // register bus: address and data taken in either order
    if (awvalid && s.awready) begin
      n.aw_got  = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.w_got  = 1'b1;
      n.wbyte  = wdata[7:0];
      n.wstrb0 = wstrb[0];
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = RESP_OK;
      case (s.aw_addr)
        OAR_OFS: if (s.wstrb0) begin
          n.oar = s.wbyte;
        end
        CTL_OFS: if (s.wstrb0) begin
          n.ack_en    = s.wbyte[CTL_ACK];
          n.begin_req = s.wbyte[CTL_BEG];
          n.halt_req  = s.wbyte[CTL_HALT];
          n.en        = s.wbyte[CTL_EN];
          n.irq_en    = s.wbyte[CTL_IRQ];
          sw_clear    = s.wbyte[CTL_JOB];
        end
        // data may only change while the engine is parked
        DATA_OFS: if (s.wstrb0) begin
          if (s.job_done) begin
            n.data = s.wbyte;
            n.wcol = 1'b0;
          end else begin
            n.wcol = 1'b1;
          end
        end
        STAT_OFS: ;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OK;
      n.rdata  = '0;
      case (araddr)
        OAR_OFS:  n.rdata[7:0] = s.oar;
        CTL_OFS:  n.rdata[7:0] = {s.job_done, s.ack_en, s.begin_req,
                                  s.halt_req, s.wcol, s.en, 1'b0,
                                  s.irq_en};
        // prescaler bits read as zero
        STAT_OFS: n.rdata[7:0] = s.job_done ? s.status : ST_IDLE;
        DATA_OFS: n.rdata[7:0] = s.data;
        default:  n.rresp = RESP_SLVERR;
      endcase
    end

    // ==========================================================
    // serial engine
    if (start_det) n.busy = 1'b1;
    if (stop_det)  n.busy = 1'b0;

    if (!s.en) begin
      n.phase     = PH_IDLE;
      n.scl_oe    = 1'b0;
      n.sda_oe    = 1'b0;
      n.addressed = 1'b0;
      n.pend      = 1'b0;
    end else if ((start_det || stop_det) && s.addressed &&
                 !s.job_done && s.phase != PH_HOLD) begin
      // the address after a restart is missed while this is parked
      n.status    = ST_STOP;
      hw_set      = 1'b1;
      n.phase     = PH_HOLD;
      n.sda_oe    = 1'b0;
      n.addressed = 1'b0;
    end else if (start_det && s.phase != PH_HOLD &&
                 s.phase != PH_GEN_START) begin
      n.phase  = PH_ADDR;
      n.bitcnt = 4'h0;
      n.sda_oe = 1'b0;
      if (s.pend) n.arb = 1'b1;
    end else if (stop_det && s.phase == PH_ADDR) begin
      n.phase = PH_IDLE;
    end else begin
      unique case (s.phase)
        PH_IDLE: if (s.pend && !s.busy && !s.job_done && scl_s) begin
          n.phase  = PH_GEN_START;
          n.timer  = START_HOLD_CYC;
          n.sda_oe = 1'b1;
        end
        PH_GEN_START: if (s.timer == 9'h000) begin
          n.scl_oe = 1'b1;
          n.status = ST_START;
          hw_set   = 1'b1;
          n.pend   = 1'b0;
          n.phase  = PH_HOLD;
        end else begin
          n.timer = s.timer - 9'h001;
        end
        PH_ADDR: begin
          if (scl_rise && s.bitcnt < 4'h8) begin
            n.shift  = {s.shift[6:0], sda_s};
            n.bitcnt = s.bitcnt + 4'h1;
          end
          if (scl_fall && s.bitcnt == 4'h8) begin
            own = s.shift[7:1] == s.oar[7:1];
            gcm = s.shift[7:1] == GC_ADDR && !s.shift[0] &&
                  s.oar[OAR_GCE];
            if (s.ack_en && (own || gcm)) begin
              n.sda_oe    = 1'b1;
              n.gc        = !own;
              n.rd        = s.shift[0];
              n.addressed = 1'b1;
              n.phase     = PH_ADDR_ACK;
            end else begin
              n.phase = PH_IDLE;
              n.arb   = 1'b0;
            end
          end
        end
        PH_ADDR_ACK: if (scl_fall) begin
          n.sda_oe = 1'b0;
          n.scl_oe = 1'b1;
          hw_set   = 1'b1;
          n.arb    = 1'b0;
          if (s.rd) begin
            n.status = s.arb ? ST_ST_ARB : ST_ST_ADDR;
          end else if (s.gc) begin
            n.status = s.arb ? ST_GC_ARB : ST_GC_ADDR;
          end else begin
            n.status = s.arb ? ST_SR_ARB : ST_SR_ADDR;
          end
          n.phase = PH_HOLD;
        end
        PH_RX: begin
          if (scl_rise && s.bitcnt < 4'h8) begin
            n.shift  = {s.shift[6:0], sda_s};
            n.bitcnt = s.bitcnt + 4'h1;
          end
          if (scl_fall && s.bitcnt == 4'h8) begin
            n.data   = s.shift;
            n.sda_oe = s.ack_plan;
            n.phase  = PH_RX_ACK;
          end
        end
        PH_RX_ACK: if (scl_fall) begin
          n.sda_oe = 1'b0;
          n.scl_oe = 1'b1;
          hw_set   = 1'b1;
          if (s.gc) begin
            n.status = s.ack_plan ? ST_GC_DACK : ST_GC_DNACK;
          end else begin
            n.status = s.ack_plan ? ST_SR_DACK : ST_SR_DNACK;
          end
          n.phase = PH_HOLD;
        end
        PH_TX: if (scl_fall) begin
          if (s.bitcnt == 4'h7) begin
            n.sda_oe = 1'b0;
            n.phase  = PH_TX_ACK;
          end else begin
            n.shift  = {s.shift[6:0], 1'b1};
            n.sda_oe = ~s.shift[6];
            n.bitcnt = s.bitcnt + 4'h1;
          end
        end
        PH_TX_ACK: begin
          if (scl_rise) n.mack = !sda_s;
          if (scl_fall) begin
            n.scl_oe = 1'b1;
            hw_set   = 1'b1;
            if (!s.mack) begin
              n.status = ST_ST_DNACK;
            end else begin
              n.status = s.last ? ST_ST_LAST : ST_ST_DACK;
            end
            n.phase = PH_HOLD;
          end
        end
        PH_HOLD: if (!s.job_done) begin
          n.scl_oe = 1'b0;
          n.bitcnt = 4'h0;
          if (s.halt_req || s.status == ST_START) begin
            n.phase     = PH_IDLE;
            n.halt_req  = 1'b0;
            n.addressed = 1'b0;
            n.sda_oe    = 1'b0;
          end else if (is_exit(s.status)) begin
            n.phase     = PH_IDLE;
            n.addressed = 1'b0;
            n.gc        = 1'b0;
            n.sda_oe    = 1'b0;
            n.pend      = s.begin_req;
          end else if (s.rd) begin
            n.phase  = PH_TX;
            n.shift  = s.data;
            n.sda_oe = ~s.data[7];
            n.last   = !s.ack_en;
          end else begin
            n.phase    = PH_RX;
            n.ack_plan = s.ack_en;
          end
        end
        default: n.phase = PH_IDLE;
      endcase
    end

    // a hardware set in the same cycle as a clear wins
    n.job_done = (s.job_done & ~sw_clear) | hw_set;
    n.awready  = !n.aw_got && !n.bvalid;
    n.wready   = !n.w_got && !n.bvalid;
    n.arready  = !n.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s      <= '0;
      s.data <= DATA_RST;
    end else begin
      s <= n;
    end
  end

  // ==========================================================
  // outputs
  assign awready = s.awready;
  assign wready  = s.wready;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = s.arready;
  assign rvalid  = s.rvalid;
  assign rdata   = s.rdata;
  assign rresp   = s.rresp;
  assign scl_oe  = s.scl_oe;
  assign sda_oe  = s.sda_oe;
  // open drain: only ever pulls low
  assign scl_o   = 1'b0;
  assign sda_o   = 1'b0;

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_gc_ack;
    s.en && s.phase == PH_RX_ACK && scl_fall && s.gc && s.ack_plan
    |=> s.job_done && s.status == ST_GC_DACK;
  endproperty
  a_gc_ack: assert property (p_gc_ack)
    else $error("general call ack data code wrong");

  property p_gc_nack_exit;
    s.en && s.phase == PH_HOLD && !s.job_done && !s.halt_req &&
    s.status == ST_GC_DNACK |=> s.phase == PH_IDLE && !s.addressed;
  endproperty
  a_gc_nack_exit: assert property (p_gc_nack_exit)
    else $error("no return to unaddressed after nack");

  property p_stop_addr;
    s.en && (start_det || stop_det) && s.addressed && !s.job_done &&
    s.phase != PH_HOLD |=> s.job_done && s.status == ST_STOP;
  endproperty
  a_stop_addr: assert property (p_stop_addr)
    else $error("stop while addressed not reported");

  property p_queue_start;
    s.en && s.phase == PH_HOLD && !s.job_done && !s.halt_req &&
    is_exit(s.status) && s.begin_req |=> s.pend && s.phase == PH_IDLE;
  endproperty
  a_queue_start: assert property (p_queue_start)
    else $error("start not queued on exit");

  property p_no_ack_off;
    s.en && s.phase == PH_ADDR && scl_fall && s.bitcnt == 4'h8 &&
    !s.ack_en |=> !s.sda_oe && s.phase == PH_IDLE;
  endproperty
  a_no_ack_off: assert property (p_no_ack_off)
    else $error("address acknowledged while ack disabled");

  property p_addr_flag;
    s.en && s.phase == PH_ADDR_ACK && scl_fall
    |=> s.job_done && s.scl_oe ##1 s.scl_oe;
  endproperty
  a_addr_flag: assert property (p_addr_flag)
    else $error("address phase did not raise flag");

  property p_last_ack;
    s.en && s.phase == PH_TX_ACK && scl_fall && s.last && s.mack
    |=> s.status == ST_ST_LAST && s.job_done;
  endproperty
  a_last_ack: assert property (p_last_ack)
    else $error("last byte ack code wrong");

  property p_release;
    s.en && s.phase == PH_HOLD && !s.job_done && !s.halt_req &&
    (s.status == ST_ST_DNACK || s.status == ST_ST_LAST)
    |=> !s.sda_oe [*4];
  endproperty
  a_release: assert property (p_release)
    else $error("data line driven after last byte");

  property p_stretch;
    s.job_done && s.phase == PH_HOLD && s.status != ST_STOP
    |-> s.scl_oe;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("clock not held while flag set");

  property p_data_first;
    s.en && s.phase == PH_RX && scl_fall && s.bitcnt == 4'h8
    |=> s.data == $past(s.shift) && s.phase == PH_RX_ACK;
  endproperty
  a_data_first: assert property (p_data_first)
    else $error("byte not stored before flag");

endmodule : two_wire_slave_engine

/* rtl/two_wire_pkg.sv */
/*
  Constants shared by the two-wire slave engine: register offsets, control
  field positions, reset values, status codes, phases and timing counts.
  Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.

*/
package two_wire_pkg;

  typedef logic [3:0]  addr_t;
  typedef logic [31:0] word_t;

  // ==========================================================
  // register offsets
  localparam addr_t OAR_OFS  = 4'h0;
  localparam addr_t CTL_OFS  = 4'h4;
  localparam addr_t STAT_OFS = 4'h8;
  localparam addr_t DATA_OFS = 4'hc;

  // ==========================================================
  // control field positions
  localparam int CTL_JOB  = 7;
  localparam int CTL_ACK  = 6;
  localparam int CTL_BEG  = 5;
  localparam int CTL_HALT = 4;
  localparam int CTL_WCOL = 3;
  localparam int CTL_EN   = 2;
  localparam int CTL_IRQ  = 0;
  localparam int OAR_GCE  = 0;

  // ==========================================================
  // reset values, bus answers and the general call address
  localparam logic [7:0] DATA_RST    = 8'hff;
  localparam logic [1:0] RESP_OK     = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [6:0] GC_ADDR     = 7'h00;

  // ==========================================================
  // status codes
  localparam logic [7:0] ST_START    = 8'h08;
  localparam logic [7:0] ST_SR_ADDR  = 8'h60;
  localparam logic [7:0] ST_SR_ARB   = 8'h68;
  localparam logic [7:0] ST_GC_ADDR  = 8'h70;
  localparam logic [7:0] ST_GC_ARB   = 8'h78;
  localparam logic [7:0] ST_SR_DACK  = 8'h80;
  localparam logic [7:0] ST_SR_DNACK = 8'h88;
  localparam logic [7:0] ST_GC_DACK  = 8'h90;
  localparam logic [7:0] ST_GC_DNACK = 8'h98;
  localparam logic [7:0] ST_STOP     = 8'ha0;
  localparam logic [7:0] ST_ST_ADDR  = 8'ha8;
  localparam logic [7:0] ST_ST_ARB   = 8'hb0;
  localparam logic [7:0] ST_ST_DACK  = 8'hb8;
  localparam logic [7:0] ST_ST_DNACK = 8'hc0;
  localparam logic [7:0] ST_ST_LAST  = 8'hc8;
  localparam logic [7:0] ST_IDLE     = 8'hf8;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int T_START_HOLD_NS = 4000;
  localparam logic [8:0] START_HOLD_CYC =
    9'((T_START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // engine phases
  typedef enum logic [3:0] {
    PH_IDLE      = 4'h0,
    PH_ADDR      = 4'h1,
    PH_ADDR_ACK  = 4'h2,
    PH_RX        = 4'h3,
    PH_RX_ACK    = 4'h4,
    PH_TX        = 4'h5,
    PH_TX_ACK    = 4'h6,
    PH_HOLD      = 4'h7,
    PH_GEN_START = 4'h8
  } phase_t;

endpackage : two_wire_pkg

/* rtl/bit_sync.sv */
/*
  Two-flop synchroniser for a bundle of independent levels.
  Assumes each bit is a slow level; no bus coherency across bits.
*/
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 2
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_t;

  sync_t s_r;
  sync_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = d;
    s_nxt.q    = s_r.meta;
  end

  // lines idle high, so reset to ones to avoid a false start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;
endmodule : bit_sync

/* rtl/line_events.sv */
/*
  Edge and condition detector for the synchronised clock and data lines.
  Assumes both inputs are already synchronised to aclk.
*/
`timescale 1ns/1ps
module line_events (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);
  typedef struct packed {
    logic scl;
    logic sda;
  } prev_t;

  prev_t p_r;
  prev_t p_nxt;

  always_comb begin
    p_nxt     = p_r;
    p_nxt.scl = scl;
    p_nxt.sda = sda;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p_r <= '1;
    end else begin
      p_r <= p_nxt;
    end
  end

  assign scl_rise  = scl & ~p_r.scl;
  assign scl_fall  = ~scl & p_r.scl;
  // data moving while clock stays high marks a condition
  assign start_det = scl & p_r.scl & p_r.sda & ~sda;
  assign stop_det  = scl & p_r.scl & ~p_r.sda & sda;
endmodule : line_events

/* tb/wire_master_model.sv */
/* serial-side master model: start, stop, byte send and receive.
   assumes the bench resolves both lines with pull-ups. */
`timescale 1ns/1ps
module wire_master_model (
  input  wire logic aclk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe,
  output logic      sda_oe
);
  // ==========================================================
  // bit timing: 8 clocks a phase, three phases a bit give the 240 ns link period
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  task automatic ph();
    repeat (8) @(posedge aclk);
  endtask : ph
  // waits out the slave holding the clock low, bounded
  task automatic rise();
    int n;
    scl_oe <= 1'b0;
    ph();
    n = 0;
    while (scl !== 1'b1) begin
      @(posedge aclk);
      n++;
      if (n > 6000) two_wire_slave_engine_bench.tmo();
    end
    ph();
  endtask : rise
  task automatic bit_io(input logic b, output logic s);
    sda_oe <= ~b;
    ph();
    rise();
    s = sda;
    scl_oe <= 1'b1;
  endtask : bit_io
  task automatic start();
    sda_oe <= 1'b1;
    ph();
    scl_oe <= 1'b1;
    ph();
  endtask : start
  task automatic stop();
    sda_oe <= 1'b1;
    ph();
    rise();
    sda_oe <= 1'b0;
    ph();
  endtask : stop
  // msb first, ninth bit is the acknowledge
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : send
  task automatic recv(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~mack, s);
  endtask : recv
endmodule : wire_master_model

/* tb/two_wire_slave_engine_bench.sv */
/* self-checking bench: register tasks on the register bus, a serial
   master model on the lines. assumes pulled-up open-drain lines. */
`timescale 1ns/1ps
module two_wire_slave_engine_bench;
  import two_wire_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb;
  addr_t awaddr, araddr;
  word_t wdata, rdata;
  int fails, checked;
  wire scl = ~(scl_oe | m_scl);
  wire sda = ~(sda_oe | m_sda);
  two_wire_slave_engine uut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  wire_master_model mst (.aclk(aclk), .scl(scl), .sda(sda),
    .scl_oe(m_scl), .sda_oe(m_sda));
  always #5 aclk = ~aclk;
  // ==========================================================
  // checking and closing
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic tmo();
    fails++;
    tally_and_finish();
  endtask : tmo
  task automatic chk(input string nm, input logic [7:0] e, s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // ==========================================================
  // register bus tasks; waits are bounded
  // ready lines stay high so back-to-back calls never toggle them
  task automatic wr(input addr_t a, input logic [7:0] d);
    int n;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 200);
    if (n >= 200) tmo();
    chk("bresp", {6'h0, RESP_OK}, {6'h0, bresp});
  endtask : wr
  task automatic rd(input addr_t a, output logic [7:0] d, logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    if (n >= 200) tmo();
    d = rdata[7:0];
    r = rresp;
  endtask : rd
  // polls the flag, then compares the status code
  task automatic code(input logic [7:0] e);
    logic [7:0] v;
    logic [1:0] r;
    int n;
    n = 0;
    do begin
      rd(CTL_OFS, v, r);
      n++;
    end while (v[CTL_JOB] !== 1'b1 && n < 3000);
    if (n >= 3000) tmo();
    rd(STAT_OFS, v, r);
    chk("status", e, v & 8'hf8);
  endtask : code
  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] v;
    logic [1:0] r;
    logic a;
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, fails, checked} = '0;
    wstrb = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(CTL_OFS, v, r);
    chk("ctl reset", 8'h00, v);
    rd(STAT_OFS, v, r);
    chk("idle code", ST_IDLE, v);
    rd(4'h2, v, r);
    chk("unmapped", {6'h0, RESP_SLVERR}, {6'h0, r});
    wr(DATA_OFS, 8'h5a);
    rd(CTL_OFS, v, r);
    chk("collision", 8'h01 << CTL_WCOL, v);
    rd(DATA_OFS, v, r);
    chk("data kept", DATA_RST, v);
    $display("test registers done");
    wr(OAR_OFS, 8'ha1);
    wr(CTL_OFS, 8'h44);
    mst.start();
    mst.send(8'ha0, a);
    chk("addr ack", 8'h01, a);
    code(ST_SR_ADDR);
    chk("stretch", 8'h01, scl_oe);
    wr(CTL_OFS, 8'hc4);
    mst.send(8'h3c, a);
    code(ST_SR_DACK);
    rd(DATA_OFS, v, r);
    chk("rx byte", 8'h3c, v);
    wr(CTL_OFS, 8'hc4);
    mst.stop();
    code(ST_STOP);
    wr(CTL_OFS, 8'he4);
    code(ST_START);
    chk("own start", 8'h00, sda);
    wr(CTL_OFS, 8'hd4);
    repeat (30) @(posedge aclk);
    $display("test receive done");
    mst.start();
    mst.send(8'h00, a);
    chk("gc ack", 8'h01, a);
    code(ST_GC_ADDR);
    wr(CTL_OFS, 8'hc4);
    mst.send(8'h5a, a);
    code(ST_GC_DACK);
    rd(DATA_OFS, v, r);
    chk("gc byte", 8'h5a, v);
    wr(CTL_OFS, 8'h84);
    mst.send(8'h11, a);
    chk("gc nack", 8'h00, a);
    code(ST_GC_DNACK);
    wr(CTL_OFS, 8'hc4);
    mst.stop();
    repeat (40) @(posedge aclk);
    rd(STAT_OFS, v, r);
    chk("unaddressed", ST_IDLE, v);
    wr(OAR_OFS, 8'ha0);
    mst.start();
    mst.send(8'h00, a);
    chk("gc off", 8'h00, a);
    mst.stop();
    wr(CTL_OFS, 8'h04);
    mst.start();
    mst.send(8'ha0, a);
    chk("ack off", 8'h00, a);
    mst.stop();
    wr(CTL_OFS, 8'h44);
    mst.start();
    mst.send(8'ha0, a);
    chk("resume", 8'h01, a);
    code(ST_SR_ADDR);
    wr(CTL_OFS, 8'hc4);
    mst.stop();
    code(ST_STOP);
    wr(CTL_OFS, 8'hc4);
    $display("test general call done");
    // nack ends the first pass, ack the second
    for (int i = 0; i < 2; i++) begin
      mst.start();
      mst.send(8'ha1, a);
      code(ST_ST_ADDR);
      wr(DATA_OFS, 8'h96);
      wr(CTL_OFS, 8'h84);
      mst.recv(i == 1, v);
      chk("tx byte", 8'h96, v);
      code(i == 1 ? ST_ST_LAST : ST_ST_DNACK);
      wr(CTL_OFS, 8'hc4);
      mst.recv(1'b0, v);
      chk("released", 8'hff, v);
      mst.stop();
    end
    // a queued start meets a foreign restart, so arbitration is lost
    mst.start();
    mst.send(8'ha1, a);
    code(ST_ST_ADDR);
    wr(CTL_OFS, 8'h84);
    mst.recv(1'b0, v);
    code(ST_ST_DNACK);
    wr(CTL_OFS, 8'he4);
    mst.rise();
    mst.start();
    mst.send(8'ha1, a);
    code(ST_ST_ARB);
    wr(CTL_OFS, 8'h84);
    mst.recv(1'b0, v);
    chk("arb tx byte", 8'h96, v);
    code(ST_ST_DNACK);
    wr(CTL_OFS, 8'hc4);
    mst.stop();
    $display("test transmit done");
    tally_and_finish();
  end
endmodule : two_wire_slave_engine_bench
